// ### rtl/klrc_pkg.sv
// package: shared constants and carrier types for the keypad control block
package klrc_pkg;
   // identification screen time in milliseconds
   localparam int unsigned IDENT_MS = 3000;
   // clock rate in kHz (200 MHz)
   localparam int unsigned CLK_KHZ = 200000;
   // identification screen time in clock cycles
   localparam int unsigned IDENT_CYCLES = IDENT_MS * CLK_KHZ;
   // width of the parameter list index
   localparam int unsigned IDX_W = 8;
   // width of a parameter value and of a speed reference
   localparam int unsigned VAL_W = 16;
   // number of menu levels
   localparam int unsigned MENU_LEVELS = 5;
   // reset values
   localparam logic RST_SEQ_LOCAL = 1'b0;
   localparam logic RST_REF_LOCAL = 1'b0;
   localparam logic RST_DIR_REV = 1'b0;
   // fixed screen indices for the setpoint screens
   localparam logic [7:0] SCR_REMOTE_SETPOINT = 8'h01;
   localparam logic [7:0] SCR_LOCAL_SETPOINT = 8'h02;
   // first index inside a freshly entered menu level
   localparam logic [7:0] IDX_FIRST = 8'h00;
   // number of keys
   localparam int unsigned NKEYS = 11;

   // display view of one panel
   typedef enum logic [2:0] {
      KLRC_VIEW_IDENT,
      KLRC_VIEW_NAV,
      KLRC_VIEW_EDIT,
      KLRC_VIEW_CMD,
      KLRC_VIEW_LSET,
      KLRC_VIEW_RSET
   } klrc_view_t;

   // debounced keys of one operator panel
   typedef struct packed {
      logic up;
      logic down;
      logic esc;
      logic menu;
      logic operator_menu_swap_key;
      logic local_remote;
      logic dir;
      logic jog;
      logic run;
      logic halt;
      logic spare;
   } klrc_keys_t;

   // navigation state of one operator panel
   typedef struct packed {
      logic [2:0] level;
      logic [7:0] index;
      logic in_oper;
      logic [2:0] save_level;
      logic [7:0] save_index;
   } klrc_nav_t;

   // remote terminal commands
   typedef struct packed {
      logic run;
      logic jog;
      logic stop;
      logic rev;
   } klrc_remote_t;
endpackage

// ### rtl/klrc_top.sv
// module: key handling and local/remote control source for the operator panel
//
// Overview of operation
// R1: toggle key swaps both sources, always accepted
// R2: mode gates keys; remote inputs ignored when local
// R3: reset starts remote, local keys disabled
// R4: ident screen timed, then remote setpoint shown
// R5: up navigates up, increments, confirms command
// R6: down navigates down, decrements when editing
// R7: escape goes back, leaves edit, acknowledges trip
// R8: menu descends; writable parameter enters edit
// R9: swap key toggles operator and saved positions
// R10: toggle jumps to setpoint; local adjusts reference
// R11: direction key only with local reference
// R12: jog while held, only stopped and local
// R13: run clears trips and starts in the same cycle, local only
// R14: halt stops if local; resets inactive trips always
// R15: separate navigation state per panel
// R16: sequencing and reference sources held independently
// R17: run and jog exclusive; stop before change
// R18: actions fire on debounced rising edge
`timescale 1ns/10ps
`default_nettype none
module klrc_top #(
   parameter int unsigned NPANEL = 2,
   parameter int unsigned IDENT_CYCLES = klrc_pkg::IDENT_CYCLES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // debounced keys, one set per panel (pin domain)
   input wire klrc_pkg::klrc_keys_t [NPANEL-1:0] keys_i,
   // remote terminal commands (pin domain)
   input wire klrc_pkg::klrc_remote_t remote_i,
   input wire logic [klrc_pkg::VAL_W-1:0] remote_ref_i,
   // drive sequencer status
   input wire logic stopped_i,
   input wire logic trip_active_i,
   input wire logic trip_latched_i,
   // parameter store information on shown parameter
   input wire logic [NPANEL-1:0] writable_i,
   input wire logic [NPANEL-1:0] cmd_menu_i,
   input wire logic [klrc_pkg::VAL_W-1:0] inch_speed_reference_i,
   // control source state
   output logic seq_local_o,
   output logic ref_local_o,
   // sequencer commands
   output logic run_o,
   output logic jog_o,
   output logic stop_o,
   output logic dir_rev_o,
   output logic trip_reset_o,
   output logic [klrc_pkg::VAL_W-1:0] speed_ref_o,
   output logic [klrc_pkg::VAL_W-1:0] local_ref_o,
   // per-panel display and edit actions
   output klrc_pkg::klrc_view_t [NPANEL-1:0] view_o,
   output klrc_pkg::klrc_nav_t [NPANEL-1:0] nav_o,
   output logic [NPANEL-1:0] edit_ind_o,
   output logic [NPANEL-1:0] inc_o,
   output logic [NPANEL-1:0] dec_o,
   output logic [NPANEL-1:0] confirm_o,
   output logic [NPANEL-1:0] msg_ack_o
);
   // elaboration check on parameters
   if (NPANEL < 1 || NPANEL > 4 || IDENT_CYCLES < 1) begin : g_chk
      $error("klrc_top: unsupported parameter values");
   end

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers: three stages, change taken when 2 and 3 agree
   localparam int unsigned KW = klrc_pkg::NKEYS;
   localparam int unsigned RW = 4;
   localparam int unsigned SW = NPANEL * KW + RW + 3;
   logic [SW-1:0] raw;
   logic [SW-1:0] s1, s2, s3, filt;
   logic [SW-1:0] next_s1, next_s2, next_s3, next_filt;
   assign raw = {keys_i, remote_i, stopped_i, trip_active_i,
      trip_latched_i};

   // stage values and agreement filter
   always_comb begin
      next_s1 = raw;
      next_s2 = s1;
      next_s3 = s2;
      next_filt = filt;
      for (int i = 0; i < SW; i++) begin
         // accept a level only once stages two and three agree
         if (s2[i] == s3[i]) begin
            next_filt[i] = s3[i];
         end
      end
   end

   // register synchroniser stages
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         filt <= '0;
      end else begin
         s1 <= next_s1;
         s2 <= next_s2;
         s3 <= next_s3;
         filt <= next_filt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // key edge detection
   klrc_pkg::klrc_keys_t [NPANEL-1:0] kl, kprev, kpress;
   klrc_pkg::klrc_remote_t rl;
   logic st_stopped, st_trip_act, st_trip_lat;
   logic lat_prev; // latched trip level of the previous cycle
   assign kl = filt[SW-1 -: NPANEL*KW];
   assign rl = filt[RW+2:3];
   assign st_stopped = filt[2];
   assign st_trip_act = filt[1];
   assign st_trip_lat = filt[0];
   // rising edge of each key gives one action per press
   assign kpress = kl & ~kprev; // R18

   // register previous key levels
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         kprev <= '0;
         lat_prev <= 1'b0;
      end else begin
         kprev <= kl;
         lat_prev <= st_trip_lat;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // shared control source and sequencer command state
   logic next_seq_local, next_ref_local, next_run, next_jog, next_stop;
   logic next_dir_rev, next_trip_reset;
   logic [klrc_pkg::VAL_W-1:0] next_speed_ref, next_local_ref;
   logic any_toggle;

   // combine key actions of all panels into the drive commands
   always_comb begin
      next_seq_local = seq_local_o;
      next_ref_local = ref_local_o;
      next_run = run_o;
      next_jog = 1'b0;
      next_stop = 1'b0;
      next_dir_rev = dir_rev_o;
      next_trip_reset = 1'b0;
      next_local_ref = local_ref_o;
      any_toggle = 1'b0;
      for (int p = 0; p < NPANEL; p++) begin
         // toggle key works in every mode
         if (kpress[p].local_remote) begin
            any_toggle = 1'b1; // R1
         end
         // local keys only while the matching source is local, except the halt trip reset, which acts in either mode
         if (ref_local_o && kpress[p].dir) begin
            next_dir_rev = ~next_dir_rev; // R11 R2
         end
         if (seq_local_o && kpress[p].run && !jog_o) begin
            // clear trips and start the run together, both in the same cycle
            next_trip_reset = 1'b1; // R13
            next_run = 1'b1; // R13 R17
         end
         if (kpress[p].halt) begin
            if (seq_local_o) begin
               next_run = 1'b0; // R14
               next_stop = 1'b1; // R14
            end
            if (!st_trip_act) begin
               next_trip_reset = 1'b1; // R14
            end
         end
         // jog held, only from stopped and not while running
         if (seq_local_o && kl[p].jog && !run_o && (jog_o || st_stopped))
         begin
            next_jog = 1'b1; // R12 R17
         end
         // setpoint adjust on local setpoint screen
         if (ref_local_o && view_o[p] == klrc_pkg::KLRC_VIEW_LSET) begin
            if (kpress[p].up) begin
               next_local_ref = next_local_ref + 1'b1; // R10
            end
            if (kpress[p].down) begin
               next_local_ref = next_local_ref - 1'b1; // R10
            end
         end
      end
      // remote terminals drive the sequencer only while remote
      if (!seq_local_o) begin
         next_run = rl.run && !rl.jog && !rl.stop && !jog_o; // R2 R17
         next_jog = rl.jog && !rl.run && !run_o &&
            (jog_o || st_stopped); // R2 R17
         next_stop = rl.stop; // R2
      end
      if (!ref_local_o) begin
         next_dir_rev = rl.rev; // R2
      end
      // both sources flip together, each kept as its own state
      if (any_toggle) begin
         next_seq_local = ~seq_local_o; // R1 R16
         next_ref_local = ~ref_local_o; // R1 R16
         next_run = 1'b0;
         next_jog = 1'b0;
      end
      // speed reference follows the active run kind and source
      if (jog_o) begin
         next_speed_ref = inch_speed_reference_i; // R12
      end else if (ref_local_o) begin
         next_speed_ref = local_ref_o;
      end else begin
         next_speed_ref = remote_ref_i;
      end
      // a newly latched trip drops a local run; a run press resets it
      if (st_trip_lat && !lat_prev && !next_trip_reset && seq_local_o) begin
         next_run = 1'b0; // R13
      end
      // run wins when run and jog would start together
      if (next_run) begin
         next_jog = 1'b0; // R17
      end
   end

   // register control and command state
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         seq_local_o <= klrc_pkg::RST_SEQ_LOCAL; // R3
         ref_local_o <= klrc_pkg::RST_REF_LOCAL; // R3
         run_o <= 1'b0;
         jog_o <= 1'b0;
         stop_o <= 1'b0;
         dir_rev_o <= klrc_pkg::RST_DIR_REV;
         trip_reset_o <= 1'b0;
         speed_ref_o <= '0;
         local_ref_o <= '0;
      end else begin
         seq_local_o <= next_seq_local;
         ref_local_o <= next_ref_local;
         run_o <= next_run;
         jog_o <= next_jog;
         stop_o <= next_stop;
         dir_rev_o <= next_dir_rev;
         trip_reset_o <= next_trip_reset;
         speed_ref_o <= next_speed_ref;
         local_ref_o <= next_local_ref;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // identification screen timer
   logic [$clog2(IDENT_CYCLES+1)-1:0] ident_cnt, next_ident_cnt;
   logic ident_done, next_ident_done;

   // count the identification interval once after reset
   always_comb begin
      next_ident_cnt = ident_cnt;
      next_ident_done = ident_done;
      if (!ident_done) begin
         if (ident_cnt == ($bits(ident_cnt))'(IDENT_CYCLES - 1)) begin
            next_ident_done = 1'b1; // R4
         end else begin
            next_ident_cnt = ident_cnt + 1'b1;
         end
      end
   end

   // register timer
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         ident_cnt <= '0;
         ident_done <= 1'b0;
      end else begin
         ident_cnt <= next_ident_cnt;
         ident_done <= next_ident_done;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-panel navigation and editing, one copy per panel
   for (genvar p = 0; p < NPANEL; p++) begin : g_panel
      klrc_pkg::klrc_view_t next_view;
      klrc_pkg::klrc_nav_t next_nav;
      logic next_inc, next_dec, next_conf, next_ack;

      // key decode for this panel
      always_comb begin
         next_view = view_o[p];
         next_nav = nav_o[p];
         next_inc = 1'b0;
         next_dec = 1'b0;
         next_conf = 1'b0;
         next_ack = 1'b0;
         case (view_o[p])
            klrc_pkg::KLRC_VIEW_IDENT: begin
               // timeout or menu key leaves the welcome screen
               if (ident_done) begin
                  next_view = klrc_pkg::KLRC_VIEW_RSET; // R4
                  next_nav.index = klrc_pkg::SCR_REMOTE_SETPOINT;
               end else if (kpress[p].menu) begin
                  next_view = klrc_pkg::KLRC_VIEW_NAV;
               end
            end
            klrc_pkg::KLRC_VIEW_NAV, klrc_pkg::KLRC_VIEW_LSET,
            klrc_pkg::KLRC_VIEW_RSET: begin
               if (kpress[p].up && view_o[p] != klrc_pkg::KLRC_VIEW_LSET)
               begin
                  next_nav.index = nav_o[p].index - 1'b1; // R5
               end else if (kpress[p].down &&
                  view_o[p] != klrc_pkg::KLRC_VIEW_LSET) begin
                  next_nav.index = nav_o[p].index + 1'b1; // R6
               end else if (kpress[p].esc) begin
                  next_view = klrc_pkg::KLRC_VIEW_NAV;
                  next_ack = 1'b1; // R7
                  if (nav_o[p].level != '0) begin
                     next_nav.level = nav_o[p].level - 1'b1; // R7
                  end
               end else if (kpress[p].menu) begin
                  next_view = klrc_pkg::KLRC_VIEW_NAV;
                  if (cmd_menu_i[p]) begin
                     next_view = klrc_pkg::KLRC_VIEW_CMD;
                  end else if (writable_i[p]) begin
                     next_view = klrc_pkg::KLRC_VIEW_EDIT; // R8
                  end else if (nav_o[p].level !=
                     3'(klrc_pkg::MENU_LEVELS - 1)) begin
                     next_nav.level = nav_o[p].level + 1'b1; // R8
                     next_nav.index = klrc_pkg::IDX_FIRST; // R8
                  end
               end else if (kpress[p].operator_menu_swap_key) begin
                  // swap current and saved position
                  next_nav.in_oper = ~nav_o[p].in_oper; // R9
                  next_nav.level = nav_o[p].save_level; // R9
                  next_nav.index = nav_o[p].save_index; // R9
                  next_nav.save_level = nav_o[p].level; // R9
                  next_nav.save_index = nav_o[p].index; // R9
                  next_view = klrc_pkg::KLRC_VIEW_NAV;
               end
            end
            klrc_pkg::KLRC_VIEW_EDIT: begin
               next_inc = kpress[p].up; // R5
               next_dec = kpress[p].down; // R6
               if (kpress[p].esc) begin
                  next_view = klrc_pkg::KLRC_VIEW_NAV; // R7
                  next_ack = 1'b1; // R7
               end
            end
            klrc_pkg::KLRC_VIEW_CMD: begin
               if (kpress[p].up) begin
                  next_conf = 1'b1; // R5
               end
               if (kpress[p].esc) begin
                  next_view = klrc_pkg::KLRC_VIEW_NAV; // R7
                  next_ack = 1'b1;
               end
            end
            default: begin
               next_view = klrc_pkg::KLRC_VIEW_NAV;
            end
         endcase
         // a toggle from any panel jumps to the new setpoint screen
         if (any_toggle) begin
            next_view = seq_local_o ? klrc_pkg::KLRC_VIEW_RSET
               : klrc_pkg::KLRC_VIEW_LSET; // R10
            next_nav.index = seq_local_o ? klrc_pkg::SCR_REMOTE_SETPOINT
               : klrc_pkg::SCR_LOCAL_SETPOINT; // R10
         end
      end

      // register panel state, kept apart per panel
      always_ff @(posedge clk_i) begin
         if (!nrst_i) begin
            view_o[p] <= klrc_pkg::KLRC_VIEW_IDENT; // R4
            nav_o[p] <= '0; // R15
            edit_ind_o[p] <= 1'b0;
            inc_o[p] <= 1'b0;
            dec_o[p] <= 1'b0;
            confirm_o[p] <= 1'b0;
            msg_ack_o[p] <= 1'b0;
         end else begin
            view_o[p] <= next_view; // R15
            nav_o[p] <= next_nav; // R15
            edit_ind_o[p] <= (next_view == klrc_pkg::KLRC_VIEW_EDIT); // R8
            inc_o[p] <= next_inc;
            dec_o[p] <= next_dec;
            confirm_o[p] <= next_conf;
            msg_ack_o[p] <= next_ack;
         end
      end
   end
endmodule
`default_nettype wire

// ### rtl/unused_placeholder_none.sv
// file: intentionally empty companion unit
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ### testbench/keypad_local_remote_control_tb.sv
// testbench: keypad control block driven by the operator model
`timescale 1ns/10ps
`default_nettype none
module keypad_local_remote_control_tb;
   // key positions inside the packed key struct
   localparam int K_UP = 10, K_DN = 9, K_ESC = 8, K_MENU = 7;
   localparam int K_LR = 5, K_DIR = 4, K_JOG = 3, K_RUN = 2, K_HALT = 1;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   klrc_pkg::klrc_keys_t [1:0] keys;
   klrc_pkg::klrc_remote_t remote_i = '0;
   logic [15:0] remote_ref_i = 16'h0000;
   logic stopped_i = 1'b1;
   logic trip_active_i = 1'b0;
   logic trip_latched_i = 1'b0;
   logic [1:0] writable_i = 2'h0;
   logic [1:0] cmd_menu_i = 2'h0;
   logic [15:0] inch_ref = 16'h0000;
   logic seq_local_o, ref_local_o, run_o, jog_o, stop_o, dir_rev_o;
   logic trip_reset_o;
   logic [15:0] local_ref_o, r, speed_ref_o;
   logic [1:0] edit_ind_o, inc_o, dec_o, confirm_o, msg_ack_o;
   logic [31:0] pc = 32'h0; // panel 0 pulse counts, one byte per kind
   klrc_pkg::klrc_view_t [1:0] view_o;
   klrc_pkg::klrc_nav_t [1:0] nav_o;
   int errors = 0;
   int num_checks = 0;
   logic [31:0] seed = 32'h726E;
   logic [6:0] exq[$]; // expected {seq,ref,run,jog,dir,trip_reset,stop}
   logic [6:0] cur;
   logic [4:0] plv;
   ////////////////////////////////////////////////////////////////////////
   always #2.5 clk_i = ~clk_i;
   klrc_operator #(.NPANEL(2)) op (.clk_i(clk_i), .keys_o(keys));
   klrc_top #(.NPANEL(2), .IDENT_CYCLES(20)) dut (
      .clk_i(clk_i), .nrst_i(nrst_i), .keys_i(keys), .remote_i(remote_i),
      .remote_ref_i(remote_ref_i), .stopped_i(stopped_i),
      .trip_active_i(trip_active_i), .trip_latched_i(trip_latched_i),
      .writable_i(writable_i), .cmd_menu_i(cmd_menu_i),
      .inch_speed_reference_i(inch_ref), .seq_local_o(seq_local_o),
      .ref_local_o(ref_local_o), .run_o(run_o), .jog_o(jog_o),
      .stop_o(stop_o), .dir_rev_o(dir_rev_o), .trip_reset_o(trip_reset_o),
      .speed_ref_o(speed_ref_o), .local_ref_o(local_ref_o), .view_o(view_o),
      .nav_o(nav_o), .edit_ind_o(edit_ind_o), .inc_o(inc_o), .dec_o(dec_o),
      .confirm_o(confirm_o), .msg_ack_o(msg_ack_o));
   // count panel 0 pulses: increment, decrement, confirm, acknowledge
   always @(negedge clk_i) pc += {inc_o[0], 7'h0, dec_o[0], 7'h0,
      confirm_o[0], 7'h0, msg_ack_o[0]};
   ////////////////////////////////////////////////////////////////////////
   // compare one value, count it, report a difference
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // verdict and end of run
   task automatic summarize();
      if (errors == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // next pseudo random word
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   ////////////////////////////////////////////////////////////////////////
   // watcher: every change of control state or pulse takes the oldest note
   always @(negedge clk_i) begin
      cur = {seq_local_o, ref_local_o, run_o, jog_o, dir_rev_o,
             trip_reset_o, stop_o};
      if (!nrst_i) begin
         plv = cur[6:2];
      end else if (cur[6:2] !== plv || cur[1:0] !== 2'b00) begin
         plv = cur[6:2];
         if (exq.size() == 0) begin
            check({25'h0, cur}, 32'hFF);
         end else begin
            check({25'h0, cur}, {25'h0, exq.pop_front()});
         end
      end
   end
   // watchdog: far beyond the planned sequence
   initial begin
      repeat (20000) @(posedge clk_i);
      errors++;
      summarize();
   end
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (2) @(negedge clk_i);
      nrst_i = 1'b1;
      repeat (30) @(negedge clk_i);
      for (int p = 0; p < 2; p++) begin
         check(32'(view_o[p]), 32'(klrc_pkg::KLRC_VIEW_RSET));
      end
      // local keys do nothing in remote mode
      op.press(0, K_RUN, 3);
      op.press(1, K_DIR, 3);
      op.press(0, K_JOG, 3);
      // remote run, jog and direction terminals work in remote mode
      for (int b = 3; b >= 0; b--) begin
         if (b != 1) begin
            exq.push_back(b == 0 ? 7'h04 : 7'h02 << b);
            remote_i[b] = 1'b1;
            repeat (12) @(negedge clk_i);
            exq.push_back(7'h00);
            remote_i[b] = 1'b0;
            repeat (12) @(negedge clk_i);
         end
      end
      // toggle from the second panel: both sources local
      exq.push_back(7'b1100000);
      op.press(1, K_LR, 3);
      for (int p = 0; p < 2; p++) begin
         check(32'(view_o[p]), 32'(klrc_pkg::KLRC_VIEW_LSET));
         check(32'(nav_o[p].index), 32'(klrc_pkg::SCR_LOCAL_SETPOINT));
      end
      // up then down on the local setpoint adjusts the keypad reference
      r = local_ref_o;
      op.press(0, K_UP, 2);
      check(32'(local_ref_o > r), 32'h1);
      op.press(0, K_DN, 2);
      check(32'(local_ref_o), 32'(r));
      // remote terminal ignored while local
      remote_i.run = 1'b1;
      repeat (12) @(negedge clk_i);
      remote_i.run = 1'b0;
      repeat (12) @(negedge clk_i);
      exq.push_back(7'b1100100);
      op.press(0, K_DIR, 3);
      trip_latched_i = 1'b1;
      exq.push_back(7'b1110110);
      op.press(0, K_RUN, 3);
      stopped_i = 1'b0;
      trip_latched_i = 1'b0;
      op.press(1, K_JOG, 3);
      trip_active_i = 1'b1;
      exq.push_back(7'b1100101);
      op.press(0, K_HALT, 3);
      stopped_i = 1'b1;
      trip_active_i = 1'b0;
      // jog while held; run pressed meanwhile is ignored
      seed = xs(seed);
      inch_ref = seed[15:0];
      exq.push_back(7'b1101100);
      exq.push_back(7'b1100100);
      fork
         op.press(0, K_JOG, 40);
         begin
            repeat (15) @(negedge clk_i);
            check(speed_ref_o, inch_ref);
            op.press(1, K_RUN, 4);
         end
      join
      exq.push_back(7'b1100000);
      op.press(1, K_DIR, 3);
      exq.push_back(7'b0000000);
      op.press(0, K_LR, 3);
      // halt in remote still resets trips once the cause is gone
      exq.push_back(7'b0000010);
      op.press(1, K_HALT, 3);
      // edit a writable parameter, then confirm inside a command menu
      writable_i = 2'h1;
      op.press(0, K_MENU, 3);
      check(edit_ind_o[0], 32'h1);
      op.press(0, K_UP, 3);
      op.press(0, K_DN, 3);
      op.press(0, K_ESC, 3);
      check(edit_ind_o[0], 32'h0);
      cmd_menu_i = 2'h1;
      op.press(0, K_MENU, 3);
      op.press(0, K_UP, 3);
      op.press(0, K_ESC, 3);
      check(pc, 32'h01010102);
      // random navigation on random panels with random parameter info
      for (int i = 0; i < 40; i++) begin
         seed = xs(seed);
         writable_i = seed[1:0];
         cmd_menu_i = seed[3:2];
         remote_ref_i = seed[31:16];
         inch_ref = seed[23:8];
         op.press(int'(seed[4]), 6 + int'(seed[7:5]) % 5,
            1 + int'(seed[10:8]));
      end
      check(speed_ref_o, remote_ref_i);
      check(32'(exq.size()), 32'h0);
      summarize();
   end
endmodule
`default_nettype wire

// ### testbench/klrc_checker.sv
// checker: concurrent properties on the keypad control block ports
`timescale 1ns/10ps
`default_nettype none
module klrc_checker #(
   parameter int unsigned NPANEL = 2,
   parameter int unsigned IDENT_CYCLES = 20
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // control source and sequencer outputs
   input wire logic seq_local_o,
   input wire logic ref_local_o,
   input wire logic run_o,
   input wire logic jog_o,
   input wire logic stop_o,
   input wire logic trip_reset_o,
   // panel outputs
   input wire klrc_pkg::klrc_view_t [NPANEL-1:0] view_o,
   input wire logic [NPANEL-1:0] edit_ind_o,
   input wire logic [NPANEL-1:0] inc_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   ////////////////////////////////////////////////////////////////////////
   // cycles since reset release, saturating so it never wraps
   logic [31:0] cnt;
   logic [31:0] next_cnt;
   always_comb begin
      next_cnt = (cnt == 32'hFFFFFFFF) ? cnt : cnt + 32'h1;
   end
   always_ff @(posedge clk_i) begin
      cnt <= nrst_i ? next_cnt : 32'h0;
   end
   ////////////////////////////////////////////////////////////////////////
   // reset leaves both sources remote and the motor idle
   a_reset_remote: assert property (@(posedge clk_i) disable iff (1'b0)
      !nrst_i |=> !seq_local_o && !ref_local_o && !run_o && !jog_o)
      else $error("control not remote after reset");
   // identification screen stands through the first half of its time
   a_ident_shown: assert property ((cnt < IDENT_CYCLES / 2) |->
      view_o[0] == klrc_pkg::KLRC_VIEW_IDENT &&
      view_o[NPANEL-1] == klrc_pkg::KLRC_VIEW_IDENT)
      else $error("identification screen left early");
   // sources only ever move together through the toggle
   a_sources_pair: assert property ($changed(seq_local_o) |->
      $changed(ref_local_o) && seq_local_o == ref_local_o)
      else $error("sources toggled apart");
   // entering local jumps the first and last panels to the local setpoint screen
   a_local_view: assert property ($rose(seq_local_o) |->
      view_o[0] == klrc_pkg::KLRC_VIEW_LSET &&
      view_o[NPANEL-1] == klrc_pkg::KLRC_VIEW_LSET)
      else $error("local setpoint screen not shown");
   // leaving local jumps to the remote setpoint screen
   a_remote_view: assert property ($fell(seq_local_o) |->
      view_o[0] == klrc_pkg::KLRC_VIEW_RSET)
      else $error("remote setpoint screen not shown");
   // run and jog never together
   a_run_jog_excl: assert property (!(run_o && jog_o))
      else $error("run and jog both active");
   // a local start always carries the trip reset
   a_run_resets: assert property ($rose(run_o) && seq_local_o |->
      trip_reset_o)
      else $error("local run without trip reset");
   // a local stop ends running at once
   a_stop_halts: assert property (stop_o && seq_local_o |-> !run_o)
      else $error("run still active at stop");
   // trip reset is a single cycle pulse
   a_trip_pulse: assert property (trip_reset_o |=> !trip_reset_o)
      else $error("trip reset longer than a cycle");
   // edit indicator exactly in the edit view
   a_edit_ind: assert property (edit_ind_o[0] ==
      (view_o[0] == klrc_pkg::KLRC_VIEW_EDIT))
      else $error("edit indicator outside edit view");
   // increment is one action per press
   a_inc_once: assert property (inc_o[0] |=> !inc_o[0])
      else $error("increment repeated");
   // main scenarios reached
   c_run: cover property ($rose(run_o));
   c_jog: cover property ($rose(jog_o));
   c_local: cover property ($rose(seq_local_o));
   c_remote_reset: cover property (trip_reset_o && !seq_local_o);
endmodule
bind klrc_top klrc_checker #(.NPANEL(NPANEL), .IDENT_CYCLES(IDENT_CYCLES)) chk (
   .clk_i(clk_i), .nrst_i(nrst_i), .seq_local_o(seq_local_o),
   .ref_local_o(ref_local_o), .run_o(run_o), .jog_o(jog_o),
   .stop_o(stop_o), .trip_reset_o(trip_reset_o), .view_o(view_o),
   .edit_ind_o(edit_ind_o), .inc_o(inc_o));
`default_nettype wire

// ### testbench/klrc_operator.sv
// operator model: presses and releases panel keys like a person would
`timescale 1ns/10ps
`default_nettype none
module klrc_operator #(
   parameter int unsigned NPANEL = 2
) (
   // clock the key levels are timed against
   input wire logic clk_i,
   // debounced key levels, high while pressed
   output var klrc_pkg::klrc_keys_t [NPANEL-1:0] keys_o
);
   initial begin
      keys_o = '0;
   end
   // press one key for hold cycles, then leave it released long enough
   task automatic press(input int p, input int k, input int hold);
      @(negedge clk_i);
      keys_o[p][k] = 1'b1;
      repeat (hold) @(negedge clk_i);
      keys_o[p][k] = 1'b0;
      // released gap so the next press is a fresh edge
      repeat (10) @(negedge clk_i);
   endtask
endmodule
`default_nettype wire
